// ---- hdl/hlcf_pkg.sv ----
// Constants and carrier types for the host link command frame layer.
// Assumes a single 100 MHz core clock and an APB master with 8-bit addresses.
package hlcf_pkg;

  // ------------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------------
  localparam logic [7:0] ADR_LINK_SET  = 8'h00;
  localparam logic [7:0] ADR_STATUS    = 8'h04;
  localparam logic [7:0] ADR_FAULTS    = 8'h08;
  localparam logic [7:0] ADR_RST_TH    = 8'h0C;
  localparam logic [7:0] ADR_TMO       = 8'h10;

  // link_settings_register fields
  localparam int SET_BAUD_LSB  = 0;
  localparam int SET_TXEN      = 2;
  localparam int SET_STACK     = 3;
  localparam int SET_DIRSEL    = 4;
  localparam int SET_TMOEN     = 5;
  localparam int SET_DEV_LSB   = 8;

  // host_link_fault_flags fields
  localparam int FLT_STOP      = 0;
  localparam int FLT_RSTSEEN   = 1;
  localparam int FLT_INVALID_REQUEST_ERROR      = 2;
  localparam int FLT_WAIT      = 3;
  localparam int FLT_CRC       = 4;
  localparam int FLT_TMO       = 5;
  localparam int FLT_W         = 6;

  // Reset values
  localparam logic [31:0] LINK_SET_RST = 32'h0000_0005;
  localparam logic [15:0] RST_TH_RST   = 16'h0C80;
  localparam logic [15:0] TMO_RST      = 16'h0800;
  localparam logic [1:0]  BAUD_FALLBK  = 2'b01;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int CLK_HZ = 100_000_000;
  localparam int OVS    = 16;
  localparam logic [5:0] DIV_125K = 6'(CLK_HZ / (OVS * 125_000));
  localparam logic [5:0] DIV_250K = 6'(CLK_HZ / (OVS * 250_000));
  localparam logic [5:0] DIV_500K = 6'(CLK_HZ / (OVS * 500_000));
  localparam logic [5:0] DIV_1M   = 6'(CLK_HZ / (OVS * 1_000_000));

  // ------------------------------------------------------------------
  // Frame format
  // ------------------------------------------------------------------
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'hA001;

  typedef enum logic [2:0] {
    RQ_SRD = 3'b000, RQ_SWR = 3'b001, RQ_KRD = 3'b010, RQ_KWR = 3'b011,
    RQ_BRD = 3'b100, RQ_BWR = 3'b101, RQ_RWR = 3'b110, RQ_RSV = 3'b111
  } hlcf_rq_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } hlcf_apb_req_t;

  typedef struct packed {
    hlcf_rq_t    kind;
    logic [5:0]  dev_adr;
    logic [15:0] reg_adr;
    logic [3:0]  nbytes;
    logic [63:0] data;
    logic        rev_dir;
  } hlcf_cmd_t;

endpackage : hlcf_pkg

// ---- hdl/hlcf_core.sv ----
// Host link command frame layer: link reset, frame decode, CRC, faults.
// Assumes a byte receiver on the same clock and an APB master on the bus.
//
// The register addresses and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
module hlcf_core (
  // Clock and reset
  input  wire logic                   i_core_clk,
  input  wire logic                   i_rst,
  // APB slave
  input  wire hlcf_pkg::hlcf_apb_req_t i_apb,
  output logic [31:0]                 o_prdata,
  output logic                        o_pready,
  output logic                        o_pslverr,
  // Host RX pin and received bytes
  input  wire logic                   i_rx_pin,
  input  wire logic                   i_rx_valid,
  input  wire logic [7:0]             i_rx_byte,
  input  wire logic                   i_rx_stop_err,
  // Response transmit side
  input  wire logic                   i_resp_done,
  output logic                        o_resp_pending,
  output logic                        o_tx_permit,
  // Decoded commands
  output logic                        o_cmd_valid,
  output hlcf_pkg::hlcf_cmd_t         o_cmd,
  // Link control
  output logic [1:0]                  o_baud_sel,
  output logic                        o_ovs_tick,
  output logic                        o_send_wake,
  output logic                        o_send_clear,
  output logic                        o_stack_pass_en
);

  // ------------------------------------------------------------------
  // Frame states
  // ------------------------------------------------------------------
  typedef enum logic [6:0] {
    ST_INIT = 7'b000_0001, ST_ADR  = 7'b000_0010, ST_REGH = 7'b000_0100,
    ST_REGL = 7'b000_1000, ST_DATA = 7'b001_0000, ST_CRCH = 7'b010_0000,
    ST_CRCL = 7'b100_0000
  } hlcf_st_t;

  logic [31:0]        set_r;
  logic [15:0]        rst_th_r;
  logic [15:0]        tmo_r;
  logic [hlcf_pkg::FLT_W-1:0] flt_r;
  logic [hlcf_pkg::FLT_W-1:0] flt_set;
  logic [hlcf_pkg::FLT_W-1:0] flt_clr;
  logic               fallbk_r;
  logic [1:0]         rx_sync_r;
  logic [5:0]         tick_cnt_r;
  logic [5:0]         tick_div;
  logic               tick;
  logic [15:0]        low_cnt_r;
  logic               lr_pulse;
  logic               lr_long;
  hlcf_st_t           st_r;
  hlcf_pkg::hlcf_rq_t rq_r;
  logic [2:0]         dsz_r;
  logic [2:0]         dcnt_r;
  logic               inv_r;
  logic [5:0]         adr_r;
  logic [15:0]        reg_r;
  logic [7:0]         dat_r [0:7];
  logic [15:0]        crc_r;
  logic [15:0]        crc_fin;
  logic [15:0]        tmo_cnt_r;
  logic               tmo_hit;
  logic               end_ok;
  logic               acts;
  logic               is_read;
  logic               grp_rd_r;
  logic               resp_pend_r;
  logic               wr_acc;
  logic               rd_setup;
  logic               mapped;
  logic [63:0]        dat_flat;
  logic [2:0]         init_rq;

  function automatic logic [15:0] crc_upd(input logic [15:0] c,
                                          input logic [7:0]  b);
    logic [15:0] x;
    x = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      x = x[0] ? ((x >> 1) ^ hlcf_pkg::CRC_POLY) : (x >> 1);
    end
    return x;
  endfunction : crc_upd

  // ------------------------------------------------------------------
  // APB slave, zero wait states
  // ------------------------------------------------------------------
  assign mapped   = (i_apb.paddr == hlcf_pkg::ADR_LINK_SET) ||
                    (i_apb.paddr == hlcf_pkg::ADR_STATUS)   ||
                    (i_apb.paddr == hlcf_pkg::ADR_FAULTS)   ||
                    (i_apb.paddr == hlcf_pkg::ADR_RST_TH)   ||
                    (i_apb.paddr == hlcf_pkg::ADR_TMO);
  assign o_pready  = i_apb.psel & i_apb.penable;
  assign o_pslverr = o_pready & ~mapped;
  assign wr_acc    = o_pready & i_apb.pwrite & mapped;
  assign rd_setup  = i_apb.psel & ~i_apb.penable & ~i_apb.pwrite;

  // Read data captured in setup so the access phase sees a flop
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      unique case (i_apb.paddr)
        hlcf_pkg::ADR_LINK_SET: o_prdata <= set_r;
        hlcf_pkg::ADR_STATUS:   o_prdata <= {21'h00_0000, st_r,
                                             resp_pend_r, fallbk_r,
                                             o_baud_sel};
        hlcf_pkg::ADR_FAULTS:   o_prdata <= {26'h000_0000, flt_r};
        hlcf_pkg::ADR_RST_TH:   o_prdata <= {16'h0000, rst_th_r};
        hlcf_pkg::ADR_TMO:      o_prdata <= {16'h0000, tmo_r};
        default:                o_prdata <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      set_r    <= hlcf_pkg::LINK_SET_RST;
      rst_th_r <= hlcf_pkg::RST_TH_RST;
      tmo_r    <= hlcf_pkg::TMO_RST;
    end else if (wr_acc) begin
      if (i_apb.paddr == hlcf_pkg::ADR_LINK_SET) begin
        set_r <= {18'h0_0000, i_apb.pwdata[13:8], 2'b00, i_apb.pwdata[5:0]};
      end
      if (i_apb.paddr == hlcf_pkg::ADR_RST_TH) begin
        rst_th_r <= i_apb.pwdata[15:0];
      end
      if (i_apb.paddr == hlcf_pkg::ADR_TMO) begin
        tmo_r <= i_apb.pwdata[15:0];
      end
    end
  end

  // ------------------------------------------------------------------
  // Baud in use and oversampling tick
  // ------------------------------------------------------------------
  // Fallback holds until software rewrites the settings register
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      fallbk_r <= 1'b0;
    end else if (lr_pulse) begin
      fallbk_r <= 1'b1;
    end else if (wr_acc && i_apb.paddr == hlcf_pkg::ADR_LINK_SET) begin
      fallbk_r <= 1'b0;
    end
  end

  assign o_baud_sel = fallbk_r ? hlcf_pkg::BAUD_FALLBK
                               : set_r[hlcf_pkg::SET_BAUD_LSB +: 2];

  always_comb begin
    unique case (o_baud_sel)
      2'b00:   tick_div = hlcf_pkg::DIV_125K;
      2'b01:   tick_div = hlcf_pkg::DIV_250K;
      2'b10:   tick_div = hlcf_pkg::DIV_500K;
      default: tick_div = hlcf_pkg::DIV_1M;
    endcase
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      tick_cnt_r <= 6'h00;
    end else if (tick) begin
      tick_cnt_r <= 6'h00;
    end else begin
      tick_cnt_r <= tick_cnt_r + 6'h01;
    end
  end

  assign tick       = (tick_cnt_r >= tick_div - 6'h01);
  assign o_ovs_tick = tick;

  // ------------------------------------------------------------------
  // Link reset detection
  // ------------------------------------------------------------------
  // Pin is asynchronous; only the second stage is looked at
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      rx_sync_r <= 2'b11;
    end else begin
      rx_sync_r <= {rx_sync_r[0], i_rx_pin};
    end
  end

  // Counts ticks, not bytes, so framing state cannot hide a long low
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      low_cnt_r <= 16'h0000;
    end else if (rx_sync_r[1]) begin
      low_cnt_r <= 16'h0000;
    end else if (tick && low_cnt_r != 16'hFFFF) begin
      low_cnt_r <= low_cnt_r + 16'h0001;
    end
  end

  assign lr_pulse = tick & ~rx_sync_r[1] &
                    (low_cnt_r == rst_th_r - 16'h0001);
  assign lr_long  = tick & ~rx_sync_r[1] & (low_cnt_r == rst_th_r);

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_send_wake  <= 1'b0;
      o_send_clear <= 1'b0;
    end else begin
      o_send_wake  <= lr_long;
      o_send_clear <= lr_long;
    end
  end

  // Link reset never gates stack traffic toward the host
  assign o_stack_pass_en = 1'b1;

  // ------------------------------------------------------------------
  // Fault flags: set wins over a write-one clear
  // ------------------------------------------------------------------
  always_comb begin
    flt_set = '0;
    flt_set[hlcf_pkg::FLT_STOP]    = i_rx_stop_err | lr_pulse;
    flt_set[hlcf_pkg::FLT_RSTSEEN] = lr_pulse;
    flt_set[hlcf_pkg::FLT_INVALID_REQUEST_ERROR]    = i_rx_valid & (st_r == ST_INIT) &
                                     i_rx_byte[7] &
                                     (i_rx_byte[6:4] == 3'b111);
    flt_set[hlcf_pkg::FLT_WAIT]    = lr_pulse & resp_pend_r & grp_rd_r;
    flt_set[hlcf_pkg::FLT_CRC]     = i_rx_valid & (st_r == ST_CRCL) &
                                     (crc_fin != 16'h0000);
    flt_set[hlcf_pkg::FLT_TMO]     = tmo_hit;
    flt_clr = (wr_acc && i_apb.paddr == hlcf_pkg::ADR_FAULTS)
              ? i_apb.pwdata[hlcf_pkg::FLT_W-1:0] : '0;
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      flt_r <= '0;
    end else begin
      flt_r <= (flt_r & ~flt_clr) | flt_set;
    end
  end

  // ------------------------------------------------------------------
  // Frame receiver
  // ------------------------------------------------------------------
  assign init_rq = i_rx_byte[6:4];
  assign crc_fin = crc_upd(crc_r, i_rx_byte);
  assign end_ok  = i_rx_valid & (st_r == ST_CRCL) &
                   (crc_fin == 16'h0000) & ~inv_r;
  assign tmo_hit = set_r[hlcf_pkg::SET_TMOEN] & (st_r != ST_INIT) &
                   ~i_rx_valid & tick & (tmo_cnt_r >= tmo_r);

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      st_r  <= ST_INIT;
      rq_r  <= hlcf_pkg::RQ_SRD;
      dsz_r <= 3'h0;
      dcnt_r <= 3'h0;
      inv_r <= 1'b0;
      adr_r <= 6'h00;
      reg_r <= 16'h0000;
      crc_r <= hlcf_pkg::CRC_INIT;
    end else if (lr_pulse || tmo_hit) begin
      st_r <= ST_INIT;
    end else if (i_rx_valid) begin
      crc_r <= crc_fin;
      unique case (st_r)
        ST_INIT: begin
          crc_r <= crc_upd(hlcf_pkg::CRC_INIT, i_rx_byte);
          if (i_rx_byte[7]) begin
            rq_r   <= hlcf_pkg::hlcf_rq_t'(init_rq);
            dsz_r  <= i_rx_byte[2:0];
            dcnt_r <= 3'h0;
            inv_r  <= (init_rq == 3'b111);
            // Group commands carry no address byte
            st_r   <= (init_rq == 3'b000 || init_rq == 3'b001)
                      ? ST_ADR : ST_REGH;
          end
        end
        ST_ADR:  begin
          adr_r <= i_rx_byte[5:0];
          st_r  <= ST_REGH;
        end
        ST_REGH: begin
          reg_r[15:8] <= i_rx_byte;
          st_r        <= ST_REGL;
        end
        ST_REGL: begin
          reg_r[7:0] <= i_rx_byte;
          st_r       <= ST_DATA;
        end
        ST_DATA: begin
          dcnt_r <= dcnt_r + 3'h1;
          if (dcnt_r == dsz_r) begin
            st_r <= ST_CRCH;
          end
        end
        ST_CRCH: st_r <= ST_CRCL;
        ST_CRCL: st_r <= ST_INIT;
        default: st_r <= ST_INIT;
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rx_valid && st_r == ST_DATA) begin
      dat_r[dcnt_r] <= i_rx_byte;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      tmo_cnt_r <= 16'h0000;
    end else if (i_rx_valid || st_r == ST_INIT) begin
      tmo_cnt_r <= 16'h0000;
    end else if (tick && tmo_cnt_r != 16'hFFFF) begin
      tmo_cnt_r <= tmo_cnt_r + 16'h0001;
    end
  end

  // ------------------------------------------------------------------
  // Command acceptance
  // ------------------------------------------------------------------
  always_comb begin
    unique case (rq_r)
      hlcf_pkg::RQ_SRD, hlcf_pkg::RQ_SWR:
        acts = (adr_r == set_r[hlcf_pkg::SET_DEV_LSB +: 6]);
      hlcf_pkg::RQ_KRD, hlcf_pkg::RQ_KWR:
        acts = set_r[hlcf_pkg::SET_STACK];
      hlcf_pkg::RQ_RSV:
        acts = 1'b0;
      default:
        acts = 1'b1;
    endcase
    dat_flat = '0;
    for (int i = 0; i < 8; i++) begin
      dat_flat[8*i +: 8] = dat_r[i];
    end
  end

  assign is_read = (rq_r == hlcf_pkg::RQ_SRD) || (rq_r == hlcf_pkg::RQ_KRD) ||
                   (rq_r == hlcf_pkg::RQ_BRD);

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_cmd_valid <= 1'b0;
      o_cmd       <= '0;
    end else begin
      o_cmd_valid <= end_ok & acts;
      if (end_ok && acts) begin
        o_cmd.kind    <= rq_r;
        o_cmd.dev_adr <= adr_r;
        o_cmd.reg_adr <= reg_r;
        o_cmd.nbytes  <= {1'b0, dsz_r} + 4'h1;
        o_cmd.data    <= dat_flat;
        o_cmd.rev_dir <= set_r[hlcf_pkg::SET_DIRSEL] ^
                         (rq_r == hlcf_pkg::RQ_RWR);
      end
    end
  end

  // Held until the transmitter reports the answer sent, or until a link reset drops an owed group read
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      resp_pend_r <= 1'b0;
      grp_rd_r    <= 1'b0;
    end else if (lr_pulse && resp_pend_r && grp_rd_r) begin
      resp_pend_r <= 1'b0;
    end else if (end_ok && acts && is_read) begin
      resp_pend_r <= 1'b1;
      grp_rd_r    <= (rq_r != hlcf_pkg::RQ_SRD);
    end else if (i_resp_done) begin
      resp_pend_r <= 1'b0;
    end
  end

  assign o_resp_pending = resp_pend_r;
  assign o_tx_permit    = resp_pend_r & set_r[hlcf_pkg::SET_TXEN];

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  a_lr_baud_fall: assert property (
    lr_pulse |=> fallbk_r && o_baud_sel == hlcf_pkg::BAUD_FALLBK &&
                 flt_r[hlcf_pkg::FLT_RSTSEEN])
    else $error("link reset did not force fallback rate");
  a_lr_keeps_set: assert property (
    lr_pulse && !wr_acc |=> $stable(set_r))
    else $error("link reset changed stored settings");
  a_lr_stop_flag: assert property (
    lr_pulse |=> flt_r[hlcf_pkg::FLT_STOP])
    else $error("stop fault missing after link reset");
  a_long_low_tones: assert property (
    o_send_wake |-> o_send_clear && fallbk_r && $past(lr_long))
    else $error("wake tones without long low");
  a_wait_drop: assert property (
    lr_pulse && resp_pend_r && grp_rd_r
      |=> !resp_pend_r && flt_r[hlcf_pkg::FLT_WAIT])
    else $error("pending group read survived link reset");
  a_tx_needs_cmd: assert property (
    $rose(resp_pend_r) |-> $past(end_ok) && o_cmd_valid)
    else $error("response pending without command");
  a_stack_gate: assert property (
    end_ok && (rq_r == hlcf_pkg::RQ_KWR || rq_r == hlcf_pkg::RQ_KRD) &&
    !set_r[hlcf_pkg::SET_STACK] |=> !o_cmd_valid)
    else $error("stack command taken by non member");
  a_write_no_resp: assert property (
    o_cmd_valid && o_cmd.kind != hlcf_pkg::RQ_SRD &&
    o_cmd.kind != hlcf_pkg::RQ_KRD && o_cmd.kind != hlcf_pkg::RQ_BRD
      |-> !$rose(resp_pend_r))
    else $error("write command raised a response");
  a_rsv_invalid_request_error: assert property (
    i_rx_valid && st_r == ST_INIT && i_rx_byte[7:4] == 4'hF && !lr_pulse
      |=> flt_r[hlcf_pkg::FLT_INVALID_REQUEST_ERROR] && inv_r)
    else $error("reserved request not flagged");
  a_rev_dir: assert property (
    o_cmd_valid && o_cmd.kind == hlcf_pkg::RQ_RWR
      |-> o_cmd.rev_dir != $past(set_r[hlcf_pkg::SET_DIRSEL]))
    else $error("reverse broadcast not reversed");

endmodule : hlcf_core

// ---- bench/hlcf_host_model.sv ----
// Host side model: sends command frames as byte pulses, holds RX low.
// Assumes the byte receiver is abstracted; bytes arrive as valid pulses.
`timescale 1ns/1ps
module hlcf_host_model (
  // Clock
  input  wire logic       i_core_clk,
  // Line to the device
  output logic            o_rx_pin,
  output logic            o_rx_valid,
  output logic [7:0]      o_rx_byte,
  output logic            o_rx_stop_err
);
  initial begin
    o_rx_pin      = 1'b1;
    o_rx_valid    = 1'b0;
    o_rx_byte     = 8'h00;
    o_rx_stop_err = 1'b0;
  end
  // ------------------------------------------------------------------
  // Frame senders
  // ------------------------------------------------------------------
  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      for (int k = 0; k < 8; k++)
        c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
    end
    return c;
  endfunction : crc16

  task automatic put(input logic [7:0] b);
    @(posedge i_core_clk);
    o_rx_valid <= 1'b1;
    o_rx_byte  <= b;
    @(posedge i_core_clk);
    o_rx_valid <= 1'b0;
    o_rx_byte  <= ~b; // Stale byte never repeats the last value
    repeat (3) @(posedge i_core_clk);
  endtask : put

  // Init first, CRC last; residue over whole frame is zero unless bad flips CRC bit 0
  task automatic send_frame(input logic [7:0] q[$], input logic bad);
    logic [15:0] c;
    c = crc16(q) ^ {15'h0, bad};
    foreach (q[i]) put(q[i]);
    put(c[7:0]);
    put(c[15:8]);
  endtask : send_frame

  task automatic hold_low(input int n);
    @(posedge i_core_clk);
    o_rx_pin <= 1'b0;
    repeat (n) @(posedge i_core_clk);
    o_rx_pin <= 1'b1;
  endtask : hold_low
endmodule : hlcf_host_model

// ---- bench/tb_host_link_command_frame_layer.sv ----
// Self-checking bench for the host link command frame layer.
// Assumes hlcf_core with a zero-wait APB slave and the host model.
`timescale 1ns/1ps
module tb_host_link_command_frame_layer;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic resp_done = 1'b0;
  hlcf_pkg::hlcf_apb_req_t apb = '0;
  hlcf_pkg::hlcf_cmd_t     cmd;
  logic [31:0] prdata, r;
  logic [7:0]  rx_byte;
  logic [1:0]  baud;
  logic pready, pslverr, rx_pin, rx_valid, stop_err, pend, permit;
  logic cmd_v, wake, clr, pass, tick, e;
  logic [7:0] q[$];
  int failures = 0;
  int n_checks = 0;
  int n_cmd = 0;
  int n_wake = 0;

  always #5 clk = ~clk;
  always @(posedge clk) begin
    if (cmd_v === 1'b1) n_cmd++;
    if (wake === 1'b1 && clr === 1'b1) n_wake++;
  end

  hlcf_core i_hlcf_core (.i_core_clk(clk), .i_rst(rst), .i_apb(apb),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_rx_pin(rx_pin), .i_rx_valid(rx_valid), .i_rx_byte(rx_byte),
    .i_rx_stop_err(stop_err), .i_resp_done(resp_done),
    .o_resp_pending(pend), .o_tx_permit(permit), .o_cmd_valid(cmd_v),
    .o_cmd(cmd), .o_baud_sel(baud), .o_ovs_tick(tick),
    .o_send_wake(wake), .o_send_clear(clr), .o_stack_pass_en(pass));
  hlcf_host_model i_hlcf_host_model (.i_core_clk(clk), .o_rx_pin(rx_pin),
    .o_rx_valid(rx_valid), .o_rx_byte(rx_byte), .o_rx_stop_err(stop_err));

  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  task automatic results;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : results

  task automatic chk(input string nm, input logic [31:0] x,
                     input logic [31:0] g);
    n_checks++;
    if (g !== x) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, x, g);
    end
  endtask : chk

  // Setup, then access held until pready is sampled high
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    int n;
    @(posedge clk);
    apb <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk);
    apb.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    e = pslverr;
    apb <= '0;
    if (n >= 50) begin
      failures++;
      results();
    end
  endtask : xfer

  task automatic rdc(input logic [7:0] a, input logic [31:0] x,
                     input logic [31:0] m, input string nm);
    xfer(1'b0, a, 32'h0000_0000);
    chk(nm, x, r & m);
  endtask : rdc

  task automatic frame(input logic bad, input logic want);
    int n0;
    int n;
    n0 = n_cmd;
    i_hlcf_host_model.send_frame(q, bad);
    n = 0;
    while (n_cmd == n0 && n < 60) begin
      @(posedge clk);
      n++;
    end
    #1;
    chk("cmd seen", {31'h0, want}, {31'h0, n_cmd != n0});
  endtask : frame

  // Tick spacing in cycles at the rate in use
  task automatic tick_gap(input int x);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (tick !== 1'b1 && n < 100);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (tick !== 1'b1 && n < 100);
    chk("tick gap", 32'(x), 32'(n));
  endtask : tick_gap

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic s_regs;
    rdc(hlcf_pkg::ADR_LINK_SET, hlcf_pkg::LINK_SET_RST, '1, "settings");
    rdc(hlcf_pkg::ADR_RST_TH, 32'(hlcf_pkg::RST_TH_RST), '1, "rst th");
    rdc(hlcf_pkg::ADR_TMO, 32'(hlcf_pkg::TMO_RST), '1, "tmo");
    rdc(8'h40, 32'h0000_0000, '1, "unmapped");
    chk("slverr", 32'h1, {31'h0, e});
    chk("permit idle", 32'h0, {31'h0, permit});
  endtask : s_regs

  // Request types 0 to 6; reserved bit 3 set, two data bytes
  task automatic s_types;
    xfer(1'b1, hlcf_pkg::ADR_LINK_SET, 32'h0000_000D);
    for (int t = 0; t < 7; t++) begin
      q = {{1'b1, 3'(t), 1'b1, 3'd1}};
      if (t < 2) q.push_back(8'h00);
      q = {q, 8'h12, 8'h34, 8'hA5, 8'h5A};
      frame(1'b0, 1'b1);
      chk("kind", 32'(t), 32'(cmd.kind));
      chk("reg", 32'h0000_1234, 32'(cmd.reg_adr));
      chk("n", 32'h2, 32'(cmd.nbytes));
      chk("data", 32'h0000_5AA5, 32'(cmd.data[15:0]));
      chk("pend", 32'(t % 2 == 0 && t < 6), {31'h0, pend});
      chk("permit", 32'(t % 2 == 0 && t < 6), {31'h0, permit});
      chk("rev", 32'(t == 6), {31'h0, cmd.rev_dir});
      @(posedge clk);
      resp_done <= 1'b1;
      @(posedge clk);
      resp_done <= 1'b0;
    end
  endtask : s_types

  task automatic s_refuse;
    xfer(1'b1, hlcf_pkg::ADR_LINK_SET, hlcf_pkg::LINK_SET_RST);
    q = {8'hB0, 8'h00, 8'h01, 8'h77};
    frame(1'b0, 1'b0);
    q = {8'hF0, 8'h00, 8'h01, 8'h77};
    frame(1'b0, 1'b0);
    rdc(hlcf_pkg::ADR_FAULTS, 32'h0000_0004, 32'h3F, "invalid_request_error");
    xfer(1'b1, hlcf_pkg::ADR_FAULTS, 32'h0000_003F);
    q = {8'hD0, 8'h00, 8'h01, 8'h77};
    frame(1'b1, 1'b0);
    rdc(hlcf_pkg::ADR_FAULTS, 32'h0000_0010, 32'h3F, "crc");
    xfer(1'b1, hlcf_pkg::ADR_FAULTS, 32'h0000_003F);
    // Cut frame: init byte only, timeout enabled
    xfer(1'b1, hlcf_pkg::ADR_TMO, 32'h0000_0004);
    xfer(1'b1, hlcf_pkg::ADR_LINK_SET, 32'h0000_0025);
    i_hlcf_host_model.put(8'h90);
    repeat (200) @(posedge clk);
    rdc(hlcf_pkg::ADR_FAULTS, 32'h0000_0020, 32'h3F, "tmo");
    xfer(1'b1, hlcf_pkg::ADR_FAULTS, 32'h0000_003F);
  endtask : s_refuse

  // Link reset with a broadcast read answer owed
  task automatic s_lreset;
    xfer(1'b1, hlcf_pkg::ADR_LINK_SET, 32'h0000_0007);
    #1;
    chk("baud set", 32'h3, 32'(baud));
    xfer(1'b1, hlcf_pkg::ADR_RST_TH, 32'h0000_0004);
    q = {8'hC0, 8'h00, 8'h01, 8'h00};
    frame(1'b0, 1'b1);
    chk("pend", 32'h1, {31'h0, pend});
    i_hlcf_host_model.hold_low(300);
    repeat (5) @(posedge clk);
    rdc(hlcf_pkg::ADR_FAULTS, 32'h0000_000B, 32'h3F, "lr");
    chk("pend drop", 32'h0, {31'h0, pend});
    chk("baud", 32'(hlcf_pkg::BAUD_FALLBK), 32'(baud));
    tick_gap(hlcf_pkg::DIV_250K);
    rdc(hlcf_pkg::ADR_LINK_SET, 32'h0000_0007, '1, "stored");
    rdc(hlcf_pkg::ADR_STATUS, 32'h0000_0005, 32'hF, "status");
    chk("wake", 32'h1, 32'(n_wake));
    chk("pass", 32'h1, {31'h0, pass});
  endtask : s_lreset

  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    s_regs();
    s_types();
    s_refuse();
    s_lreset();
    results();
  end
endmodule : tb_host_link_command_frame_layer
